// ==== rtl/nafp_alu.sv ====
`timescale 1ns/100ps
`include "nafp_cfg.svh"

module nafp_alu import nafp_pkg::*; #(
    parameter int DATA_W = `NAFP_DATA_W,
    parameter int BIDIR_N = `NAFP_BIDIR_N
) (
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    input wire logic i_exec,
    input wire nafp_req_type i_req,
    input wire logic i_int_accept,
    input wire nafp_flags_type i_stack_flags,
    input wire logic [DATA_W-1:0] i_key_input_port,
    input wire logic [BIDIR_N*DATA_W-1:0] i_bidir_pins,
    input wire logic [DATA_W-1:0] i_periph_status,
    output logic [DATA_W-1:0] o_working_register,
    output nafp_flags_type o_flags,
    output nafp_flags_type o_saved_flags,
    output logic o_saved_valid,
    output logic o_branch_taken,
    output logic o_done,
    output logic [DATA_W-1:0] o_low_output_port,
    output logic [DATA_W-1:0] o_high_output_port,
    output logic [BIDIR_N*DATA_W-1:0] o_bidir_latch
);

    // sum with carry out: bit DATA_W is the carry
    function automatic logic [DATA_W:0] add_c(
        input logic [DATA_W-1:0] a,
        input logic [DATA_W-1:0] b,
        input logic cin
    );
        add_c = {1'b0, a} + {1'b0, b} + {{DATA_W{1'b0}}, cin};
    endfunction

    // port address falls on one of the bidirectional ports
    function automatic logic in_bidir(input logic [`NAFP_ADDR_W-1:0] pa);
        in_bidir = (pa >= `NAFP_PA_BIDIR_LO) && (pa <= `NAFP_PA_BIDIR_HI);
    endfunction

    // which port addresses each instruction reaches
    function automatic logic port_ok(input nafp_op_type op, input logic [`NAFP_ADDR_W-1:0] pa);
        logic bidir;
        logic scan;
        bidir = in_bidir(pa);
        scan = (pa >= `NAFP_PA_BIDIR_LO) && (pa <= `NAFP_PA_SCAN_HI);
        case (op)
            NAFP_OP_IN: port_ok = (pa == `NAFP_PA_KEY_P1) || (pa == `NAFP_PA_P1) || (pa == `NAFP_PA_P2)
                || bidir || (pa == `NAFP_PA_STATUS);
            NAFP_OP_OUT, NAFP_OP_OUTK: port_ok = (pa == `NAFP_PA_KEY_P1) || (pa == `NAFP_PA_P1)
                || (pa == `NAFP_PA_P2) || bidir;
            NAFP_OP_SETP, NAFP_OP_CLRP: port_ok = (pa == `NAFP_PA_P1) || (pa == `NAFP_PA_P2) || bidir
                || scan;
            NAFP_OP_TESTP: port_ok = (pa == `NAFP_PA_KEY_P1) || (pa == `NAFP_PA_P1)
                || (pa == `NAFP_PA_P2) || bidir || (pa == `NAFP_PA_STATUS);
            default: port_ok = 1'b0;
        endcase
    endfunction

    logic [DATA_W-1:0] acc_ff;
    logic [DATA_W-1:0] nxt_acc;
    nafp_flags_type flags_ff;
    nafp_flags_type nxt_flags;
    nafp_flags_type saved_ff;
    logic saved_valid_ff;
    logic branch_ff;
    logic done_ff;
    logic [DATA_W-1:0] p1_ff;
    logic [DATA_W-1:0] p2_ff;
    logic [DATA_W-1:0] nxt_p1;
    logic [DATA_W-1:0] nxt_p2;
    logic [DATA_W-1:0] bidir_ff [BIDIR_N];
    logic [DATA_W-1:0] nxt_bidir [BIDIR_N];
    logic [DATA_W-1:0] key_s1_ff;
    logic [DATA_W-1:0] key_s2_ff;
    logic [BIDIR_N*DATA_W-1:0] pins_s1_ff;
    logic [BIDIR_N*DATA_W-1:0] pins_s2_ff;
    logic [DATA_W:0] sum;
    logic [DATA_W-1:0] port_rd;
    logic [DATA_W-1:0] port_wr;
    logic [DATA_W-1:0] bit_mask;
    logic port_sel_ok;
    logic do_port_write;
    logic [2:0] bidir_idx;
    logic is_bidir;

    // two-stage synchronisers for pins, inputs are never latched beyond this
    always_ff @(posedge i_ref_clk) begin
        key_s1_ff <= i_key_input_port;
        key_s2_ff <= key_s1_ff;
    end

    always_ff @(posedge i_ref_clk) begin
        pins_s1_ff <= i_bidir_pins;
        pins_s2_ff <= pins_s1_ff;
    end

    assign is_bidir = in_bidir(i_req.port_addr);
    assign bidir_idx = 3'(i_req.port_addr - `NAFP_PA_BIDIR_LO);
    assign port_sel_ok = port_ok(i_req.op, i_req.port_addr);
    assign bit_mask = DATA_W'(`NAFP_ONE4 << i_req.bit_sel);

    // port read mux
    always_comb begin
        port_rd = `NAFP_ZERO4;
        if (port_sel_ok) begin
            case (i_req.port_addr)
                `NAFP_PA_KEY_P1: port_rd = key_s2_ff;
                `NAFP_PA_P1: port_rd = p1_ff;
                `NAFP_PA_P2: port_rd = p2_ff;
                `NAFP_PA_STATUS: port_rd = i_periph_status;
                default: begin
                    if (is_bidir) begin
                        port_rd = pins_s2_ff[bidir_idx*DATA_W +: DATA_W];
                    end
                end
            endcase
        end
    end

    // value written to the selected output latch
    always_comb begin
        port_wr = acc_ff;
        do_port_write = 1'b0;
        case (i_req.op)
            NAFP_OP_OUT: begin
                port_wr = acc_ff;
                do_port_write = port_sel_ok;
            end
            NAFP_OP_OUTK: begin
                port_wr = i_req.operand;
                do_port_write = port_sel_ok;
            end
            NAFP_OP_SETP: begin
                port_wr = port_rd_latch(i_req.port_addr) | bit_mask;
                do_port_write = port_sel_ok;
            end
            NAFP_OP_CLRP: begin
                port_wr = port_rd_latch(i_req.port_addr) & ~bit_mask;
                do_port_write = port_sel_ok;
            end
            default: begin
                port_wr = acc_ff;
                do_port_write = 1'b0;
            end
        endcase
    end

    // latch contents of an output port, for read-modify-write bit ops
    function automatic logic [DATA_W-1:0] port_rd_latch(input logic [`NAFP_ADDR_W-1:0] pa);
        logic [2:0] idx;
        idx = 3'(pa - `NAFP_PA_BIDIR_LO);
        if (pa == `NAFP_PA_P1) begin
            port_rd_latch = p1_ff;
        end else if (pa == `NAFP_PA_P2) begin
            port_rd_latch = p2_ff;
        end else if (in_bidir(pa)) begin
            port_rd_latch = bidir_ff[idx];
        end else begin
            port_rd_latch = `NAFP_ZERO4;
        end
    endfunction

    // output latch next values; unmapped writes change nothing, but OUTB loads both paired latches at any address
    always_comb begin
        nxt_p1 = p1_ff;
        nxt_p2 = p2_ff;
        for (int k = 0; k < BIDIR_N; k++) begin
            nxt_bidir[k] = bidir_ff[k];
        end
        if (i_exec && !i_int_accept) begin
            if (do_port_write) begin
                if ((i_req.port_addr == `NAFP_PA_KEY_P1) || (i_req.port_addr == `NAFP_PA_P1)) begin
                    nxt_p1 = port_wr;
                end else if (i_req.port_addr == `NAFP_PA_P2) begin
                    nxt_p2 = port_wr;
                end else if (is_bidir) begin
                    nxt_bidir[bidir_idx] = port_wr;
                end
            end
            if (i_req.op == NAFP_OP_OUTB) begin
                nxt_p1 = i_req.operand; // 8-bit table output through the paired port
                nxt_p2 = i_req.operand_hi;
            end
        end
    end

    // arithmetic unit and flag update
    always_comb begin
        nxt_acc = acc_ff;
        nxt_flags = flags_ff;
        sum = add_c(acc_ff, i_req.operand, 1'b0);
        if (i_int_accept) begin
            nxt_flags.status_flag = 1'b1;
        end else if (i_exec) begin
            nxt_flags.status_flag = 1'b1;
            case (i_req.op)
                NAFP_OP_LOAD: begin
                    nxt_acc = i_req.operand;
                    nxt_flags.zero_flag = (i_req.operand == `NAFP_ZERO4);
                end
                NAFP_OP_ADD, NAFP_OP_ADD_WITH_CARRY: begin
                    sum = add_c(acc_ff, i_req.operand,
                        (i_req.op == NAFP_OP_ADD_WITH_CARRY) ? flags_ff.carry_flag : 1'b0);
                    nxt_acc = sum[DATA_W-1:0];
                    nxt_flags.zero_flag = (sum[DATA_W-1:0] == `NAFP_ZERO4);
                    if (i_req.op == NAFP_OP_ADD_WITH_CARRY) begin
                        nxt_flags.carry_flag = sum[DATA_W];
                    end
                    nxt_flags.status_flag = ~sum[DATA_W];
                end
                NAFP_OP_SUBR, NAFP_OP_REVERSE_SUBTRACT_WITH_CARRY: begin
                    sum = add_c(i_req.operand, ~acc_ff,
                        (i_req.op == NAFP_OP_REVERSE_SUBTRACT_WITH_CARRY) ? flags_ff.carry_flag : 1'b1);
                    nxt_acc = sum[DATA_W-1:0];
                    nxt_flags.zero_flag = (sum[DATA_W-1:0] == `NAFP_ZERO4);
                    if (i_req.op == NAFP_OP_REVERSE_SUBTRACT_WITH_CARRY) begin
                        nxt_flags.carry_flag = sum[DATA_W];
                    end
                    nxt_flags.status_flag = sum[DATA_W];
                end
                NAFP_OP_AND, NAFP_OP_OR, NAFP_OP_XOR: begin
                    case (i_req.op)
                        NAFP_OP_AND: nxt_acc = acc_ff & i_req.operand;
                        NAFP_OP_OR: nxt_acc = acc_ff | i_req.operand;
                        default: nxt_acc = acc_ff ^ i_req.operand;
                    endcase
                    nxt_flags.zero_flag = (nxt_acc == `NAFP_ZERO4);
                    nxt_flags.status_flag = (nxt_acc != `NAFP_ZERO4);
                end
                NAFP_OP_ROTL: begin
                    nxt_acc = {acc_ff[DATA_W-2:0], flags_ff.carry_flag};
                    nxt_flags.carry_flag = acc_ff[`NAFP_MSB];
                    nxt_flags.status_flag = ~acc_ff[`NAFP_MSB];
                end
                NAFP_OP_ROTR: begin
                    nxt_acc = {flags_ff.carry_flag, acc_ff[DATA_W-1:1]};
                    nxt_flags.carry_flag = acc_ff[`NAFP_LSB];
                    nxt_flags.status_flag = ~acc_ff[`NAFP_LSB];
                end
                NAFP_OP_SETGF: begin
                    nxt_flags.general_flag = 1'b1;
                end
                NAFP_OP_CLRGF: begin
                    nxt_flags.general_flag = 1'b0;
                end
                NAFP_OP_TESTGF: begin
                    nxt_flags.status_flag = flags_ff.general_flag;
                end
                NAFP_OP_IN: begin
                    nxt_acc = port_rd;
                    nxt_flags.zero_flag = (port_rd == `NAFP_ZERO4);
                end
                NAFP_OP_TESTP: begin
                    nxt_flags.status_flag = |(port_rd & bit_mask);
                end
                NAFP_OP_RETURN_FROM_INTERRUPT: begin
                    nxt_flags = i_stack_flags;
                end
                default: begin
                    nxt_acc = acc_ff;
                end
            endcase
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            acc_ff <= `NAFP_ACC_RST;
        end else begin
            acc_ff <= nxt_acc;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            flags_ff <= `NAFP_FLAGS_RST;
        end else begin
            flags_ff <= nxt_flags;
        end
    end

    // flag save on interrupt acceptance, before status is forced
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            saved_ff <= `NAFP_FLAGS_RST;
            saved_valid_ff <= 1'b0;
        end else begin
            saved_valid_ff <= i_int_accept;
            if (i_int_accept) begin
                saved_ff <= flags_ff;
            end
        end
    end

    // branch decision uses the flag left by the previous instruction
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            branch_ff <= 1'b0;
            done_ff <= 1'b0;
        end else begin
            branch_ff <= i_exec && !i_int_accept && (i_req.op == NAFP_OP_BRANCH) && flags_ff.status_flag;
            done_ff <= i_exec && !i_int_accept;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            p1_ff <= `NAFP_LATCH_RST;
            p2_ff <= `NAFP_LATCH_RST;
        end else begin
            p1_ff <= nxt_p1;
            p2_ff <= nxt_p2;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        for (int k = 0; k < BIDIR_N; k++) begin
            if (i_sys_rst) begin
                bidir_ff[k] <= `NAFP_LATCH_RST;
            end else begin
                bidir_ff[k] <= nxt_bidir[k];
            end
        end
    end

    always_comb begin
        for (int k = 0; k < BIDIR_N; k++) begin
            o_bidir_latch[k*DATA_W +: DATA_W] = bidir_ff[k];
        end
    end

    assign o_working_register = acc_ff;
    assign o_flags = flags_ff;
    assign o_saved_flags = saved_ff;
    assign o_saved_valid = saved_valid_ff;
    assign o_branch_taken = branch_ff;
    assign o_done = done_ff;
    assign o_low_output_port = p1_ff;
    assign o_high_output_port = p2_ff;

endmodule // nafp_alu

// ==== rtl/nafp_cfg.svh ====
`ifndef NAFP_CFG_SVH
`define NAFP_CFG_SVH
// How it works
// - the arithmetic unit takes 4-bit operands, gives 4-bit result, carry and zero
// - the working register feeds one operand and takes the result
// - addition carry is the carry out of the top sum bit
// - subtraction adds the two's complement; carry 1 means no borrow
// - zero detect is 1 when result or moved value is all zero
// - condition register: carry bit 3, zero bit 2, status bit 1, general bit 0
// - interrupt acceptance saves all flags; return from interrupt restores them
// - carry flag is carry-in for add-with-carry and non-borrow for subtract-with-carry
// - rotates load the carry flag with the bit shifted out
// - zero flag takes zero detect only on instructions that update it
// - status flag set every instruction, default 1, cleared on instruction conditions
// - branch is taken only while the status flag is 1
// - status flag forced to 1 at reset and after interrupt flag save
// - general flag is a user bit: set, clear and test
// - ports are selected by a separate 5-bit address space, 0 to 31
// - each port instruction reaches only its own set of port addresses, except OUTB, which writes P1 and P2 at any address
// - output ports hold written data in latches; inputs read pins unlatched
// - peripheral status inputs are read through ports, apart from the status flag
`define NAFP_DATA_W 4
`define NAFP_ADDR_W 5
`define NAFP_BIDIR_N 6
`define NAFP_ACC_RST 4'h0
`define NAFP_FLAGS_RST 4'h2
`define NAFP_LATCH_RST 4'hF
`define NAFP_ZERO4 4'h0
`define NAFP_ONE4 4'h1
`define NAFP_PA_KEY_P1 5'h00
`define NAFP_PA_P1 5'h01
`define NAFP_PA_P2 5'h02
`define NAFP_PA_BIDIR_LO 5'h04
`define NAFP_PA_BIDIR_HI 5'h09
`define NAFP_PA_SCAN_HI 5'h07
`define NAFP_PA_STATUS 5'h0E
`define NAFP_PA_P2P1 5'h11
`define NAFP_MSB 3
`define NAFP_LSB 0
`define NAFP_SYNC_W 2
`endif

// ==== rtl/nafp_pkg.sv ====
package nafp_pkg;
    typedef enum logic [4:0] {
        NAFP_OP_NOP = 5'h00,
        NAFP_OP_LOAD = 5'h01,
        NAFP_OP_ADD = 5'h02,
        NAFP_OP_ADD_WITH_CARRY = 5'h03,
        NAFP_OP_SUBR = 5'h04,
        NAFP_OP_REVERSE_SUBTRACT_WITH_CARRY = 5'h05,
        NAFP_OP_AND = 5'h06,
        NAFP_OP_OR = 5'h07,
        NAFP_OP_XOR = 5'h08,
        NAFP_OP_ROTL = 5'h09,
        NAFP_OP_ROTR = 5'h0A,
        NAFP_OP_SETGF = 5'h0B,
        NAFP_OP_CLRGF = 5'h0C,
        NAFP_OP_TESTGF = 5'h0D,
        NAFP_OP_IN = 5'h0E,
        NAFP_OP_OUT = 5'h0F,
        NAFP_OP_OUTK = 5'h10,
        NAFP_OP_SETP = 5'h11,
        NAFP_OP_CLRP = 5'h12,
        NAFP_OP_TESTP = 5'h13,
        NAFP_OP_OUTB = 5'h14,
        NAFP_OP_BRANCH = 5'h15,
        NAFP_OP_RETURN_FROM_INTERRUPT = 5'h16
    } nafp_op_type;

    // bit 3 carry, bit 2 zero, bit 1 status, bit 0 general
    typedef struct packed {
        logic carry_flag;
        logic zero_flag;
        logic status_flag;
        logic general_flag;
    } nafp_flags_type;

    typedef struct packed {
        nafp_op_type op;
        logic [3:0] operand;
        logic [3:0] operand_hi;
        logic [4:0] port_addr;
        logic [1:0] bit_sel;
    } nafp_req_type;
endpackage

// ==== testbench/nafp_port_model.sv ====
`timescale 1ns/100ps
module nafp_port_model (
    input wire logic [3:0] i_key_val,
    input wire logic [23:0] i_ext_drive,
    input wire logic [23:0] i_latch,
    output logic [3:0] o_key_pins,
    output logic [23:0] o_bidir_pins
);
    // key pads held steady until the bench changes them
    assign o_key_pins = i_key_val;
    // open-drain pads: a low latch bit pulls the pin low
    assign o_bidir_pins = i_latch & i_ext_drive;
endmodule // nafp_port_model

// ==== testbench/nafp_alu_chk.sv ====
`timescale 1ns/100ps
module nafp_alu_chk import nafp_pkg::*; #(
    parameter int DATA_W = 4,
    parameter int BIDIR_N = 6
) (
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    input wire logic i_exec,
    input wire nafp_req_type i_req,
    input wire logic i_int_accept,
    input wire nafp_flags_type i_stack_flags,
    input wire logic [DATA_W-1:0] o_working_register,
    input wire nafp_flags_type o_flags,
    input wire nafp_flags_type o_saved_flags,
    input wire logic o_saved_valid,
    input wire logic o_branch_taken,
    input wire logic o_done
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_sys_rst);
    logic go;
    assign go = i_exec && !i_int_accept;

    a_done_follows: assert property (o_done == $past(go))
        else $error("done pulse does not follow accepted request");
    a_int_save: assert property (i_int_accept |=> o_saved_valid && o_saved_flags == $past(o_flags))
        else $error("flags not saved on interrupt");
    a_int_status: assert property (i_int_accept |=> o_flags.status_flag && !o_done)
        else $error("status not forced or request not dropped");
    a_return_from_interrupt_restore: assert property (go && i_req.op == NAFP_OP_RETURN_FROM_INTERRUPT |=> o_flags == $past(i_stack_flags))
        else $error("flags not restored");
    a_add_sum: assert property (go && i_req.op == NAFP_OP_ADD |=>
        o_working_register == $past(o_working_register) + $past(i_req.operand)
        && o_flags.zero_flag == (o_working_register == 4'h0))
        else $error("add result or zero wrong");
    a_add_with_carry_carry: assert property (go && i_req.op == NAFP_OP_ADD_WITH_CARRY |=>
        {o_flags.carry_flag, o_working_register} == {1'b0, $past(o_working_register)}
        + $past(i_req.operand) + $past(o_flags.carry_flag))
        else $error("add with carry wrong");
    a_reverse_subtract_with_carry_borrow: assert property (go && i_req.op == NAFP_OP_REVERSE_SUBTRACT_WITH_CARRY |=>
        {o_flags.carry_flag, o_working_register} == {1'b0, $past(i_req.operand)}
        + {1'b0, ~$past(o_working_register)} + $past(o_flags.carry_flag))
        else $error("subtract with carry wrong");
    a_subr_status: assert property (go && i_req.op == NAFP_OP_SUBR |=>
        o_flags.status_flag == ($past(i_req.operand) >= $past(o_working_register)))
        else $error("status after subtract wrong");
    a_rotl_carry: assert property (go && i_req.op == NAFP_OP_ROTL |=>
        o_flags.carry_flag == $past(o_working_register[3]))
        else $error("rotate carry wrong");
    a_branch_cond: assert property (go && i_req.op == NAFP_OP_BRANCH |=>
        o_branch_taken == $past(o_flags.status_flag))
        else $error("branch decision wrong");
    a_gf_user: assert property (go && (i_req.op == NAFP_OP_SETGF || i_req.op == NAFP_OP_CLRGF) |=>
        o_flags.general_flag == ($past(i_req.op) == NAFP_OP_SETGF))
        else $error("general flag wrong");
    a_reset_vals: assert property ($fell(i_sys_rst) |-> o_flags == 4'h2 && o_working_register == 4'h0)
        else $error("reset values wrong");
endmodule // nafp_alu_chk

bind nafp_alu nafp_alu_chk #(.DATA_W(DATA_W), .BIDIR_N(BIDIR_N)) u_chk (.i_ref_clk, .i_sys_rst, .i_exec,
    .i_req, .i_int_accept, .i_stack_flags, .o_working_register, .o_flags, .o_saved_flags, .o_saved_valid,
    .o_branch_taken, .o_done);

// ==== testbench/testbench.sv ====
`timescale 1ns/100ps
module testbench import nafp_pkg::*; ;
    logic i_ref_clk, i_sys_rst, i_exec, i_int_accept, o_saved_valid, o_branch_taken, o_done;
    nafp_req_type i_req;
    nafp_flags_type i_stack_flags, o_flags, o_saved_flags;
    logic [3:0] i_key_input_port, i_periph_status, key_val, o_working_register;
    logic [3:0] o_low_output_port, o_high_output_port;
    logic [23:0] i_bidir_pins, ext_drive, o_bidir_latch;
    int num_errors, tests_run, cycles;
    int pa[8] = '{1, 2, 4, 5, 6, 7, 8, 9};

    nafp_alu #(.DATA_W(4), .BIDIR_N(6)) DUT (.i_ref_clk, .i_sys_rst, .i_exec, .i_req, .i_int_accept,
        .i_stack_flags, .i_key_input_port, .i_bidir_pins, .i_periph_status, .o_working_register, .o_flags,
        .o_saved_flags, .o_saved_valid, .o_branch_taken, .o_done, .o_low_output_port, .o_high_output_port,
        .o_bidir_latch);
    nafp_port_model u_far (.i_key_val(key_val), .i_ext_drive(ext_drive), .i_latch(o_bidir_latch),
        .o_key_pins(i_key_input_port), .o_bidir_pins(i_bidir_pins));

    initial begin
        i_ref_clk = 1'b0;
        forever #5 i_ref_clk = ~i_ref_clk;
    end

    task automatic finish_test();
        $display("errors %0d checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    always @(posedge i_ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            num_errors++;
            finish_test();
        end
    end

    task automatic chk(input logic [3:0] got, input logic [3:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %0t %s got %h want %h", $time, what, got, exp);
        end
    endtask

    task automatic chk_bus(input logic [23:0] got, input logic [23:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %0t %s got %h want %h", $time, what, got, exp);
        end
    endtask

    // one request; the paired high nibble is the complement, bit select is the low two data bits
    task automatic op(input nafp_op_type o, input logic [3:0] d, input logic [4:0] a);
        @(negedge i_ref_clk);
        i_exec = 1'b1;
        i_req = '{op: o, operand: d, operand_hi: ~d, port_addr: a, bit_sel: d[1:0]};
        @(negedge i_ref_clk);
        i_exec = 1'b0;
    endtask

    initial begin
        i_sys_rst = 1'b1;
        i_exec = 1'b0;
        i_int_accept = 1'b0;
        i_req = '0;
        i_stack_flags = 4'h9;
        i_periph_status = 4'h5;
        key_val = 4'hA;
        ext_drive = 24'hFFFFF5;
        repeat (8) @(negedge i_ref_clk);
        i_sys_rst = 1'b0;
        chk(o_flags, 4'h2, "flags after reset");
        chk(o_low_output_port, 4'hF, "latch after reset");
        op(NAFP_OP_LOAD, 4'h4, 5'h00);
        op(NAFP_OP_ADD, 4'h5, 5'h00);
        chk(o_working_register, 4'h9, "4+5");
        chk({3'h0, o_done}, 4'h1, "done");
        chk(o_flags, 4'h2, "flags 4+5");
        op(NAFP_OP_LOAD, 4'h7, 5'h00);
        op(NAFP_OP_ADD, 4'h9, 5'h00);
        chk(o_working_register, 4'h0, "7+9");
        chk(o_flags, 4'h4, "flags 7+9");
        op(NAFP_OP_BRANCH, 4'h0, 5'h00);
        chk({3'h0, o_branch_taken}, 4'h0, "branch on clear status");
        op(NAFP_OP_BRANCH, 4'h0, 5'h00);
        chk({3'h0, o_branch_taken}, 4'h1, "branch on set status");
        op(NAFP_OP_LOAD, 4'h1, 5'h00);
        op(NAFP_OP_SUBR, 4'h3, 5'h00);
        chk(o_working_register, 4'h2, "3-1");
        chk(o_flags, 4'h2, "flags 3-1");
        op(NAFP_OP_LOAD, 4'h8, 5'h00);
        op(NAFP_OP_SUBR, 4'h6, 5'h00);
        chk(o_working_register, 4'hE, "6-8");
        chk(o_flags, 4'h0, "flags 6-8");
        op(NAFP_OP_LOAD, 4'h2, 5'h00);
        op(NAFP_OP_SUBR, 4'h2, 5'h00);
        chk(o_flags, 4'h6, "flags 2-2");
        op(NAFP_OP_LOAD, 4'h8, 5'h00);
        op(NAFP_OP_ROTL, 4'h0, 5'h00);
        chk({o_flags.carry_flag, o_working_register[2:0]}, 4'h8, "rotate left");
        op(NAFP_OP_LOAD, 4'h4, 5'h00);
        op(NAFP_OP_ADD_WITH_CARRY, 4'h5, 5'h00);
        chk(o_working_register, 4'hA, "4+5+carry");
        op(NAFP_OP_LOAD, 4'h9, 5'h00);
        op(NAFP_OP_ADD_WITH_CARRY, 4'h7, 5'h00);
        chk({o_flags[3:2], o_working_register[1:0]}, 4'hC, "9+7 carry and zero");
        op(NAFP_OP_LOAD, 4'h6, 5'h00);
        op(NAFP_OP_REVERSE_SUBTRACT_WITH_CARRY, 4'h2, 5'h00);
        chk(o_working_register, 4'hC, "2-6 borrow");
        op(NAFP_OP_LOAD, 4'h1, 5'h00);
        op(NAFP_OP_REVERSE_SUBTRACT_WITH_CARRY, 4'h4, 5'h00);
        chk({o_flags.carry_flag, o_working_register[2:0]}, 4'hA, "4-1 less borrow");
        op(NAFP_OP_LOAD, 4'h1, 5'h00);
        op(NAFP_OP_ROTR, 4'h0, 5'h00);
        chk({o_flags.carry_flag, o_working_register[3:1]}, 4'hC, "rotate right");
        op(NAFP_OP_SETGF, 4'h0, 5'h00);
        op(NAFP_OP_TESTGF, 4'h0, 5'h00);
        chk({2'h0, o_flags[1:0]}, 4'h3, "general flag set");
        op(NAFP_OP_CLRGF, 4'h0, 5'h00);
        op(NAFP_OP_TESTGF, 4'h0, 5'h00);
        chk({2'h0, o_flags[1:0]}, 4'h0, "general flag clear");
        op(NAFP_OP_RETURN_FROM_INTERRUPT, 4'h0, 5'h00);
        chk(o_flags, 4'h9, "restored flags");
        @(negedge i_ref_clk);
        i_int_accept = 1'b1;
        i_exec = 1'b1;
        i_req.op = NAFP_OP_CLRGF;
        @(negedge i_ref_clk);
        i_int_accept = 1'b0;
        i_exec = 1'b0;
        i_stack_flags = 4'h4;
        chk(o_saved_flags, 4'h9, "saved flags");
        chk({o_saved_valid, o_done, 2'h0}, 4'h8, "save pulse, request dropped");
        chk(o_flags, 4'hB, "status forced");
        op(NAFP_OP_RETURN_FROM_INTERRUPT, 4'h0, 5'h00);
        chk(o_flags, 4'h4, "second restore");
        foreach (pa[i]) op(NAFP_OP_OUTK, pa[i][3:0] + 4'h3, pa[i][4:0]);
        chk_bus(o_bidir_latch, 24'hCBA987, "bidir latches");
        chk(o_low_output_port, 4'h4, "low latch");
        chk({o_high_output_port}, 4'h5, "high latch");
        op(NAFP_OP_LOAD, 4'h3, 5'h00);
        op(NAFP_OP_OUT, 4'h0, 5'h00);
        op(NAFP_OP_OUTK, 4'hE, 5'h03);
        op(NAFP_OP_OUTK, 4'hE, 5'h1F);
        chk(o_low_output_port, 4'h3, "port 0 write");
        chk_bus(o_bidir_latch, 24'hCBA987, "unused writes");
        op(NAFP_OP_IN, 4'h0, 5'h00);
        chk(o_working_register, 4'hA, "key read");
        key_val = 4'h0;
        @(negedge i_ref_clk);
        op(NAFP_OP_IN, 4'h0, 5'h00);
        chk(o_working_register, 4'h0, "key read after change");
        chk(o_flags, 4'h6, "zero after key read");
        op(NAFP_OP_IN, 4'h0, 5'h0E);
        chk(o_working_register, 4'h5, "status input");
        op(NAFP_OP_IN, 4'h0, 5'h04);
        chk(o_working_register, 4'h5, "bidir pins");
        op(NAFP_OP_IN, 4'h0, 5'h03);
        chk({o_flags.zero_flag, o_working_register[2:0]}, 4'h8, "unused read");
        op(NAFP_OP_IN, 4'h0, 5'h01);
        chk(o_working_register, 4'h3, "low latch read");
        op(NAFP_OP_OUTB, 4'h6, 5'h11);
        chk({o_high_output_port}, 4'h9, "paired high");
        op(NAFP_OP_SETP, 4'h1, 5'h02);
        op(NAFP_OP_SETP, 4'h1, 5'h00);
        chk({o_high_output_port}, 4'hB, "bit set");
        chk(o_low_output_port, 4'h6, "unreachable bit set");
        op(NAFP_OP_TESTP, 4'h2, 5'h02);
        chk({3'h0, o_flags.status_flag}, 4'h0, "tested bit");
        op(NAFP_OP_AND, 4'h6, 5'h00);
        chk(o_working_register, 4'h2, "and");
        op(NAFP_OP_OR, 4'h8, 5'h00);
        chk(o_working_register, 4'hA, "or");
        op(NAFP_OP_XOR, 4'hA, 5'h00);
        chk(o_working_register, 4'h0, "xor");
        chk(o_flags, 4'h4, "flags after xor to zero");
        op(NAFP_OP_CLRP, 4'h3, 5'h02);
        op(NAFP_OP_CLRP, 4'h0, 5'h04);
        chk(o_high_output_port, 4'h3, "bit clear");
        chk_bus(o_bidir_latch, 24'hCBA986, "bidir bit clear");
        finish_test();
    end
endmodule // testbench
